// ===== include/mitc_pkg.sv
package mitc_pkg;
	// instruction word layout
	localparam int unsigned INSN_W  = 16;
	localparam int unsigned PC_W    = 11;
	localparam int unsigned DATA_W  = 8;
	localparam int unsigned DADDR_W = 7;
	localparam int unsigned OP_W    = 5;
	localparam int unsigned OP_LO   = 11;
	localparam int unsigned DST_POS = 10;
	localparam int unsigned BIT_LO  = 7;
	localparam int unsigned BIT_W   = 3;

	// instruction cycle timing
	localparam int unsigned CLK_PERIOD_NS  = 5;
	localparam int unsigned CLKS_PER_CYCLE = 4;
	localparam logic [1:0]  PHASE_FIRST    = 2'h0;
	localparam logic [1:0]  PHASE_LAST     = 2'(CLKS_PER_CYCLE - 1);

	// reset values and low pc address
	localparam logic [PC_W-1:0]    PC_RST  = 11'h000;
	localparam logic [DATA_W-1:0]  ACC_RST = 8'h00;
	localparam logic [DADDR_W-1:0] PCL_ADDR = 7'h00;

	// clock source options
	localparam logic OSC_XTAL = 1'b0;
	localparam logic OSC_RC   = 1'b1;

	// opcodes
	localparam logic [OP_W-1:0] OP_NOP   = 5'h00;
	localparam logic [OP_W-1:0] OP_MOVAM = 5'h01;
	localparam logic [OP_W-1:0] OP_MOVMA = 5'h02;
	localparam logic [OP_W-1:0] OP_MOVAI = 5'h03;
	localparam logic [OP_W-1:0] OP_ADD   = 5'h04;
	localparam logic [OP_W-1:0] OP_ADC   = 5'h05;
	localparam logic [OP_W-1:0] OP_SUB   = 5'h06;
	localparam logic [OP_W-1:0] OP_SBC   = 5'h07;
	localparam logic [OP_W-1:0] OP_ADDI  = 5'h08;
	localparam logic [OP_W-1:0] OP_SUBI  = 5'h09;
	localparam logic [OP_W-1:0] OP_AND   = 5'h0A;
	localparam logic [OP_W-1:0] OP_OR    = 5'h0B;
	localparam logic [OP_W-1:0] OP_XOR   = 5'h0C;
	localparam logic [OP_W-1:0] OP_ANDI  = 5'h0D;
	localparam logic [OP_W-1:0] OP_TBLRD = 5'h0E;
	localparam logic [OP_W-1:0] OP_HALT  = 5'h0F;
	localparam logic [OP_W-1:0] OP_CPL   = 5'h10;
	localparam logic [OP_W-1:0] OP_INC   = 5'h11;
	localparam logic [OP_W-1:0] OP_DEC   = 5'h12;
	localparam logic [OP_W-1:0] OP_RR    = 5'h13;
	localparam logic [OP_W-1:0] OP_RL    = 5'h14;
	localparam logic [OP_W-1:0] OP_RRC   = 5'h15;
	localparam logic [OP_W-1:0] OP_RLC   = 5'h16;
	localparam logic [OP_W-1:0] OP_CLRB  = 5'h17;
	localparam logic [OP_W-1:0] OP_SETB  = 5'h18;
	localparam logic [OP_W-1:0] OP_SZ    = 5'h19;
	localparam logic [OP_W-1:0] OP_SZB   = 5'h1A;
	localparam logic [OP_W-1:0] OP_SNZB  = 5'h1B;
	localparam logic [OP_W-1:0] OP_JMP   = 5'h1C;
	localparam logic [OP_W-1:0] OP_CALL  = 5'h1D;
	localparam logic [OP_W-1:0] OP_RET   = 5'h1E;
	localparam logic [OP_W-1:0] OP_INTERRUPT_EXIT  = 5'h1F;
endpackage

// ===== rtl/mitc_alu.sv
`timescale 1ns/1ps
`default_nettype none
module mitc_alu (
	input  wire logic [4:0] op,
	input  wire logic [7:0] acc,
	input  wire logic [7:0] mem,
	input  wire logic [7:0] imm,
	input  wire logic [2:0] bsel,
	input  wire logic       cin,
	output logic      [7:0] res,
	output logic            cout,
	output logic            c_aff,
	output logic            z_aff,
	output logic            skip
);
	logic [8:0] wide;
	logic [7:0] bmask;

	assign bmask = 8'h01 << bsel;

	always_comb begin
		wide  = 9'h000;
		res   = mem;
		cout  = cin;
		c_aff = 1'b0;
		z_aff = 1'b0;
		skip  = 1'b0;
		case (op)
			mitc_pkg::OP_MOVMA: res = acc;
			mitc_pkg::OP_MOVAI: res = imm;
			mitc_pkg::OP_ADD, mitc_pkg::OP_ADC, mitc_pkg::OP_ADDI: begin
				wide = {1'b0, acc} + ((op == mitc_pkg::OP_ADDI) ? {1'b0, imm}
					: {1'b0, mem}) + {8'h00, (op == mitc_pkg::OP_ADC) & cin};
				res   = wide[7:0];
				cout  = wide[8];
				c_aff = 1'b1;
				z_aff = 1'b1;
			end
			mitc_pkg::OP_SUB, mitc_pkg::OP_SBC, mitc_pkg::OP_SUBI: begin
				wide = {1'b0, acc} - ((op == mitc_pkg::OP_SUBI) ? {1'b0, imm}
					: {1'b0, mem}) - {8'h00, (op == mitc_pkg::OP_SBC) & cin};
				res   = wide[7:0];
				cout  = wide[8];
				c_aff = 1'b1;
				z_aff = 1'b1;
			end
			mitc_pkg::OP_AND: begin
				res   = acc & mem;
				z_aff = 1'b1;
			end
			mitc_pkg::OP_OR: begin
				res   = acc | mem;
				z_aff = 1'b1;
			end
			mitc_pkg::OP_XOR: begin
				res   = acc ^ mem;
				z_aff = 1'b1;
			end
			mitc_pkg::OP_ANDI: begin
				res   = acc & imm;
				z_aff = 1'b1;
			end
			mitc_pkg::OP_CPL: begin
				res   = ~mem;
				z_aff = 1'b1;
			end
			mitc_pkg::OP_INC: begin
				res   = mem + 8'h01;
				z_aff = 1'b1;
			end
			mitc_pkg::OP_DEC: begin
				res   = mem - 8'h01;
				z_aff = 1'b1;
			end
			mitc_pkg::OP_RR: res = {mem[0], mem[7:1]};
			mitc_pkg::OP_RL: res = {mem[6:0], mem[7]};
			mitc_pkg::OP_RRC: begin
				res   = {cin, mem[7:1]};
				cout  = mem[0];
				c_aff = 1'b1;
			end
			mitc_pkg::OP_RLC: begin
				res   = {mem[6:0], cin};
				cout  = mem[7];
				c_aff = 1'b1;
			end
			mitc_pkg::OP_CLRB: res = mem & ~bmask;
			mitc_pkg::OP_SETB: res = mem | bmask;
			mitc_pkg::OP_SZ:   skip = (mem == 8'h00);
			mitc_pkg::OP_SZB:  skip = ~|(mem & bmask);
			mitc_pkg::OP_SNZB: skip = |(mem & bmask);
			default: res = mem;
		endcase
	end
endmodule
`default_nettype wire

// ===== rtl/mitc_core.sv
`timescale 1ns/1ps
`default_nettype none
module mitc_core #(
	parameter int unsigned DMEM_DEPTH     = 128,
	parameter int unsigned STACK_DEPTH    = 4,
	parameter logic        FAST_OSC_OPT   = mitc_pkg::OSC_RC,
	parameter logic        SLOW_OSC_OPT   = mitc_pkg::OSC_RC,
	parameter bit          HAS_SLOW_XTAL  = 1'b1
) (
	input  wire logic                        clk_sys,
	input  wire logic                        arst_n,
	input  wire logic [mitc_pkg::INSN_W-1:0] prog_data,
	input  wire logic                        wake,
	output logic      [mitc_pkg::PC_W-1:0]   prog_addr,
	output logic      [mitc_pkg::PC_W-1:0]   pc,
	output logic      [7:0]                  acc,
	output logic                             carry_flag,
	output logic                             zero_flag,
	output logic                             global_interrupt_enable,
	output logic                             power_down,
	output logic      [1:0]                  instr_phase,
	output logic                             instr_done,
	output logic                             fast_clk_src,
	output logic                             slow_clk_src
);
	localparam int unsigned SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

	initial begin
		if (DMEM_DEPTH < 2 || DMEM_DEPTH > (1 << mitc_pkg::DADDR_W))
			$error("data memory depth out of range");
		if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
			$error("stack depth must be a power of two");
		if (!HAS_SLOW_XTAL && SLOW_OSC_OPT == mitc_pkg::OSC_XTAL)
			$error("slow crystal not present on this variant");
	end

	typedef enum logic [1:0] {ST_RUN, ST_EXTRA, ST_SLEEP} mitc_state_e;

	mitc_state_e          state;
	logic [7:0]           dmem [DMEM_DEPTH];
	logic [mitc_pkg::PC_W-1:0] stack [STACK_DEPTH];
	logic [SP_W-1:0]      sp;
	logic                 tbl_pend;

	// instruction field decode
	logic [4:0]                   op;
	logic                         dst_mem;
	logic [2:0]                   bsel;
	logic [mitc_pkg::DADDR_W-1:0] daddr;
	logic [7:0]                   imm;
	logic [mitc_pkg::PC_W-1:0]    jaddr;

	assign op      = prog_data[mitc_pkg::OP_LO +: mitc_pkg::OP_W];
	assign dst_mem = prog_data[mitc_pkg::DST_POS];
	assign bsel    = prog_data[mitc_pkg::BIT_LO +: mitc_pkg::BIT_W];
	assign daddr   = prog_data[mitc_pkg::DADDR_W-1:0];
	assign imm     = prog_data[7:0];
	assign jaddr   = prog_data[mitc_pkg::PC_W-1:0];

	logic is_pcl;
	logic in_range;
	logic [7:0] mem_rd;

	assign is_pcl   = (daddr == mitc_pkg::PCL_ADDR);
	assign in_range = (32'(daddr) < DMEM_DEPTH);
	assign mem_rd   = is_pcl ? pc[7:0] : (in_range ? dmem[daddr] : 8'h00);

	logic [7:0] alu_res;
	logic       alu_cout;
	logic       alu_c_aff;
	logic       alu_z_aff;
	logic       alu_skip;

	mitc_alu u_alu (
		.op    (op),
		.acc   (acc),
		.mem   (mem_rd),
		.imm   (imm),
		.bsel  (bsel),
		.cin   (carry_flag),
		.res   (alu_res),
		.cout  (alu_cout),
		.c_aff (alu_c_aff),
		.z_aff (alu_z_aff),
		.skip  (alu_skip)
	);

	// destination selection
	logic dst_grp;
	logic to_mem;
	logic to_acc;
	logic pcl_jump;

	assign dst_grp = (op >= mitc_pkg::OP_CPL && op <= mitc_pkg::OP_RLC)
		|| op == mitc_pkg::OP_ADD || op == mitc_pkg::OP_ADC
		|| op == mitc_pkg::OP_SUB || op == mitc_pkg::OP_SBC
		|| op == mitc_pkg::OP_AND || op == mitc_pkg::OP_OR
		|| op == mitc_pkg::OP_XOR;
	assign to_mem = op == mitc_pkg::OP_MOVMA || op == mitc_pkg::OP_CLRB
		|| op == mitc_pkg::OP_SETB || (dst_grp && dst_mem);
	assign to_acc = op == mitc_pkg::OP_MOVAM || op == mitc_pkg::OP_MOVAI
		|| op == mitc_pkg::OP_ADDI || op == mitc_pkg::OP_SUBI
		|| op == mitc_pkg::OP_ANDI || (dst_grp && !dst_mem);
	assign pcl_jump = to_mem && is_pcl;

	// sequencing
	logic exec;
	logic extra_end;
	logic is_branch;
	logic two_cycle;
	logic [mitc_pkg::PC_W-1:0] pc_plus1;
	logic [mitc_pkg::PC_W-1:0] pc_plus2;
	logic [mitc_pkg::PC_W-1:0] stack_top;
	logic [mitc_pkg::PC_W-1:0] tbl_addr;
	logic [mitc_pkg::PC_W-1:0] next_pc;

	assign exec      = (state == ST_RUN) && (instr_phase == mitc_pkg::PHASE_LAST);
	assign extra_end = (state == ST_EXTRA) && (instr_phase == mitc_pkg::PHASE_LAST);
	assign is_branch = op == mitc_pkg::OP_JMP || op == mitc_pkg::OP_CALL
		|| op == mitc_pkg::OP_RET || op == mitc_pkg::OP_INTERRUPT_EXIT;
	assign two_cycle = is_branch || op == mitc_pkg::OP_TBLRD
		|| pcl_jump || alu_skip;
	assign pc_plus1  = pc + 11'h001;
	assign pc_plus2  = pc + 11'h002;
	assign stack_top = stack[sp - SP_W'(1)];
	assign tbl_addr  = {pc[mitc_pkg::PC_W-1:8], acc};
	assign next_pc   =
		(op == mitc_pkg::OP_JMP || op == mitc_pkg::OP_CALL) ? jaddr :
		(op == mitc_pkg::OP_RET || op == mitc_pkg::OP_INTERRUPT_EXIT) ? stack_top :
		pcl_jump ? {pc[mitc_pkg::PC_W-1:8], alu_res} :
		alu_skip ? pc_plus2 : pc_plus1;

	// phase counter and state
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			instr_phase <= mitc_pkg::PHASE_FIRST;
			state       <= ST_RUN;
		end else begin
			instr_phase <= instr_phase + 2'h1;
			if (exec && op == mitc_pkg::OP_HALT)
				state <= ST_SLEEP;
			else if (exec && two_cycle)
				state <= ST_EXTRA;
			else if (extra_end)
				state <= ST_RUN;
			else if (state == ST_SLEEP && wake
				&& instr_phase == mitc_pkg::PHASE_LAST)
				state <= ST_RUN;
		end
	end

	// program counter and fetch address
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pc        <= mitc_pkg::PC_RST;
			prog_addr <= mitc_pkg::PC_RST;
			tbl_pend  <= 1'b0;
		end else if (exec) begin
			pc        <= next_pc;
			prog_addr <= (op == mitc_pkg::OP_TBLRD) ? tbl_addr : next_pc;
			tbl_pend  <= (op == mitc_pkg::OP_TBLRD);
		end else if (extra_end) begin
			prog_addr <= pc;
			tbl_pend  <= 1'b0;
		end
	end

	// return stack
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sp <= '0;
			for (int i = 0; i < STACK_DEPTH; i++)
				stack[i] <= mitc_pkg::PC_RST;
		end else if (exec && op == mitc_pkg::OP_CALL) begin
			stack[sp] <= pc_plus1;
			sp        <= sp + SP_W'(1);
		end else if (exec && (op == mitc_pkg::OP_RET || op == mitc_pkg::OP_INTERRUPT_EXIT)) begin
			sp <= sp - SP_W'(1);
		end
	end

	// data memory
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DMEM_DEPTH; i++)
				dmem[i] <= 8'h00;
		end else if (exec && to_mem && !is_pcl && in_range) begin
			dmem[daddr] <= alu_res;
		end
	end

	// accumulator, flags, status
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			acc                     <= mitc_pkg::ACC_RST;
			carry_flag              <= 1'b0;
			zero_flag               <= 1'b0;
			global_interrupt_enable <= 1'b0;
			power_down              <= 1'b0;
			instr_done              <= 1'b0;
		end else begin
			instr_done <= (exec && !two_cycle) || extra_end;
			if (exec && to_acc)
				acc <= alu_res;
			else if (extra_end && tbl_pend)
				acc <= prog_data[7:0];
			if (exec && alu_c_aff)
				carry_flag <= alu_cout;
			if (exec && alu_z_aff)
				zero_flag <= (alu_res == 8'h00);
			if (exec && op == mitc_pkg::OP_INTERRUPT_EXIT)
				global_interrupt_enable <= 1'b1;
			if (exec && op == mitc_pkg::OP_HALT)
				power_down <= 1'b1;
			else if (state == ST_SLEEP && wake
				&& instr_phase == mitc_pkg::PHASE_LAST)
				power_down <= 1'b0;
		end
	end

	// clock source options, constants fixed at build
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			fast_clk_src <= FAST_OSC_OPT;
			slow_clk_src <= HAS_SLOW_XTAL ? SLOW_OSC_OPT : mitc_pkg::OSC_RC;
		end else begin
			fast_clk_src <= FAST_OSC_OPT;
			slow_clk_src <= HAS_SLOW_XTAL ? SLOW_OSC_OPT : mitc_pkg::OSC_RC;
		end
	end

	// checking helpers
	logic       add_ovf;
	logic [7:0] xor_val;
	assign add_ovf = ({1'b0, acc} + {1'b0, mem_rd}) > 9'h0FF;
	assign xor_val = acc ^ mem_rd;

	phase_wrap_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(instr_phase == mitc_pkg::PHASE_LAST) |=> (instr_phase == mitc_pkg::PHASE_FIRST)
			[*1] ##3 (instr_phase == mitc_pkg::PHASE_LAST))
		else $error("instruction cycle is not four clocks");

	jump_two_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(exec && op == mitc_pkg::OP_JMP)
			|=> (state == ST_EXTRA)[*4] ##1 (state == ST_RUN && instr_done))
		else $error("jump did not take two cycles");

	pcl_jump_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(exec && pcl_jump)
			|=> (pc[7:0] == $past(alu_res) && state == ST_EXTRA))
		else $error("low pc write did not jump");

	one_cycle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(exec && !two_cycle && op != mitc_pkg::OP_HALT)
			|=> (instr_done && state == ST_RUN) ##4 (pc != $past(pc, 5) || exec))
		else $error("plain instruction did not finish in one cycle");

	skip_pc_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(exec && alu_skip) |=> (pc == $past(pc_plus2)))
		else $error("skip did not bypass the next instruction");

	ret_addr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(exec && op == mitc_pkg::OP_RET) |=> (pc == $past(stack_top)))
		else $error("return address wrong");

	add_carry_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(exec && op == mitc_pkg::OP_ADD) |=> (carry_flag == $past(add_ovf)))
		else $error("add carry wrong");

	xor_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(exec && op == mitc_pkg::OP_XOR) |=> (zero_flag == ($past(xor_val) == 8'h00)))
		else $error("zero flag wrong after xor");

	interrupt_exit_gie_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(exec && op == mitc_pkg::OP_INTERRUPT_EXIT) |=> global_interrupt_enable)
		else $error("interrupt exit did not set enable");

	ret_gie_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(exec && op == mitc_pkg::OP_RET)
			|=> (global_interrupt_enable == $past(global_interrupt_enable)))
		else $error("plain exit changed enable");

	cfg_fixed_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		1'b1 |=> ($stable(fast_clk_src) && $stable(slow_clk_src)))
		else $error("clock option changed at run time");

	reset_pc_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$rose(arst_n) |-> (pc == mitc_pkg::PC_RST
			&& instr_phase == mitc_pkg::PHASE_FIRST))
		else $error("pc not at reset value");
endmodule
`default_nettype wire

// ===== sim/mitc_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
module mitc_prog_mem #(
	parameter int DELAY_NS = 12
) (
	input  wire logic [mitc_pkg::PC_W-1:0]   addr,
	output logic      [mitc_pkg::INSN_W-1:0] data
);
	logic [mitc_pkg::INSN_W-1:0] mem [2**mitc_pkg::PC_W];
	// word after access time, old word meanwhile
	assign #(DELAY_NS) data = mem[addr];
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
	$display("MISMATCH %s expected %h seen %h", n, e, g); \
	fail_count++; end end
module tb;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic        wake = 1'b0;
	logic [15:0] prog_data;
	logic [10:0] prog_addr;
	logic [10:0] pc;
	logic [7:0]  acc;
	logic        carry_flag;
	logic        zero_flag;
	logic        gie;
	logic        power_down;
	logic [1:0]  instr_phase;
	logic        instr_done;
	logic        fast_src;
	logic        slow_src;
	int          fail_count = 0;
	int          total_checks = 0;
	int          gap;

	always #2.5 clk_sys = ~clk_sys;

	mitc_core #(
		.FAST_OSC_OPT (mitc_pkg::OSC_XTAL),
		.SLOW_OSC_OPT (mitc_pkg::OSC_XTAL),
		.HAS_SLOW_XTAL(1'b1)
	) i_dut (
		.clk_sys                (clk_sys),
		.arst_n                 (arst_n),
		.prog_data              (prog_data),
		.wake                   (wake),
		.prog_addr              (prog_addr),
		.pc                     (pc),
		.acc                    (acc),
		.carry_flag             (carry_flag),
		.zero_flag              (zero_flag),
		.global_interrupt_enable(gie),
		.power_down             (power_down),
		.instr_phase            (instr_phase),
		.instr_done             (instr_done),
		.fast_clk_src           (fast_src),
		.slow_clk_src           (slow_src)
	);

	mitc_prog_mem #(.DELAY_NS(12)) i_mem (.addr(prog_addr), .data(prog_data));

	function automatic logic [15:0] wm(logic [4:0] o, logic d, logic [2:0] b,
		logic [6:0] a);
		return {o, d, b, a};
	endfunction
	function automatic logic [15:0] wi(logic [4:0] o, logic [7:0] x);
		return {o, 3'h0, x};
	endfunction
	function automatic logic [15:0] wj(logic [4:0] o, logic [10:0] x);
		return {o, x};
	endfunction

	task p(input int a, input logic [15:0] w);
		i_mem.mem[a] = w;
	endtask

	// reset held, memory cleared to no-ops
	task restart;
		@(negedge clk_sys);
		arst_n = 1'b0;
		for (int a = 0; a < 2048; a++) i_mem.mem[a] = 16'h0000;
		repeat (8) @(negedge clk_sys);
		`CHK("pc_rst", mitc_pkg::PC_RST, pc)
		`CHK("ph_rst", mitc_pkg::PHASE_FIRST, instr_phase)
	endtask

	task go;
		@(negedge clk_sys);
		arst_n = 1'b1;
	endtask

	// waits for n completions, gap holds clocks of the last one
	task step(input int n);
		int k;
		repeat (n) begin
			k = 0;
			do begin
				@(negedge clk_sys);
				k++;
			end while (instr_done !== 1'b1 && k < 64);
			if (k >= 64) `CHK("done_seen", 1'b1, 1'b0)
			gap = k;
		end
	endtask

	task sa(input logic [7:0] e);
		step(1);
		`CHK("acc", e, acc)
	endtask

	task s_timing;
		restart();
		p(2, wj(mitc_pkg::OP_JMP, 11'h008));
		p(3, wi(mitc_pkg::OP_MOVAI, 8'h77));
		go();
		for (int i = 1; i <= 4; i++) begin
			@(negedge clk_sys);
			`CHK("phase", 2'(i), instr_phase)
			`CHK("done", 1'(i == 4), instr_done)
		end
		step(1);
		`CHK("gap_nop", 4, gap)
		step(1);
		`CHK("gap_jmp", 8, gap)
		`CHK("pc_jmp", 11'h008, pc)
		`CHK("paddr_jmp", 11'h008, prog_addr)
		step(1);
		`CHK("gap_nop2", 4, gap)
		`CHK("pc_next", 11'h009, pc)
		`CHK("acc_kept", 8'h00, acc)
	endtask

	task s_alu;
		restart();
		p(0, wi(mitc_pkg::OP_MOVAI, 8'hF0));
		p(1, wi(mitc_pkg::OP_ADDI, 8'h20));
		p(2, wi(mitc_pkg::OP_SUBI, 8'h30));
		p(3, wi(mitc_pkg::OP_SUBI, 8'h10));
		p(4, wi(mitc_pkg::OP_MOVAI, 8'h5A));
		p(5, wm(mitc_pkg::OP_MOVMA, 0, 0, 7));
		p(6, wm(mitc_pkg::OP_XOR, 0, 0, 7));
		p(7, wm(mitc_pkg::OP_OR, 0, 0, 7));
		p(8, wm(mitc_pkg::OP_CPL, 0, 0, 7));
		p(9, wm(mitc_pkg::OP_AND, 0, 0, 7));
		go();
		sa(8'hF0);
		sa(8'h10);
		`CHK("carry", 1'b1, carry_flag)
		sa(8'hE0);
		`CHK("borrow", 1'b1, carry_flag)
		sa(8'hD0);
		`CHK("no_borrow", 1'b0, carry_flag)
		step(2);
		sa(8'h00);
		`CHK("z_xor", 1'b1, zero_flag)
		sa(8'h5A);
		`CHK("z_or", 1'b0, zero_flag)
		sa(8'hA5);
		`CHK("z_cpl", 1'b0, zero_flag)
		sa(8'h00);
		`CHK("z_and", 1'b1, zero_flag)
	endtask

	task s_mem;
		restart();
		p(0, wi(mitc_pkg::OP_MOVAI, 8'h81));
		p(1, wi(mitc_pkg::OP_ADDI, 8'h00));
		p(2, wm(mitc_pkg::OP_MOVMA, 0, 0, 5));
		p(3, wm(mitc_pkg::OP_RLC, 0, 0, 5));
		p(4, wm(mitc_pkg::OP_RRC, 0, 0, 5));
		p(5, wm(mitc_pkg::OP_INC, 1, 0, 5));
		p(6, wm(mitc_pkg::OP_MOVAM, 0, 0, 5));
		p(7, wm(mitc_pkg::OP_DEC, 0, 0, 5));
		p(8, wm(mitc_pkg::OP_MOVAM, 0, 0, 5));
		p(9, wm(mitc_pkg::OP_SETB, 0, 0, 5));
		p(10, wm(mitc_pkg::OP_CLRB, 0, 7, 5));
		p(11, wm(mitc_pkg::OP_MOVAM, 0, 0, 5));
		go();
		step(3);
		`CHK("c_clear", 1'b0, carry_flag)
		sa(8'h02);
		`CHK("c_rlc", 1'b1, carry_flag)
		sa(8'hC0);
		`CHK("c_rrc", 1'b1, carry_flag)
		step(1);
		sa(8'h82);
		sa(8'h81);
		sa(8'h82);
		step(2);
		sa(8'h03);
	endtask

	task s_skip;
		restart();
		p(1, wm(mitc_pkg::OP_MOVMA, 0, 0, 6));
		p(2, wm(mitc_pkg::OP_SZ, 0, 0, 6));
		p(3, wi(mitc_pkg::OP_MOVAI, 8'h11));
		p(4, wm(mitc_pkg::OP_SNZB, 0, 0, 6));
		p(5, wi(mitc_pkg::OP_MOVAI, 8'h22));
		go();
		step(3);
		`CHK("gap_skip", 8, gap)
		`CHK("pc_skip", 11'h004, pc)
		step(1);
		`CHK("gap_noskip", 4, gap)
		`CHK("pc_noskip", 11'h005, pc)
		sa(8'h22);
	endtask

	// carry chained add and subtract, plain rotates, bit-zero skip
	task s_more;
		restart();
		p(0, wi(mitc_pkg::OP_MOVAI, 8'h81));
		p(1, wm(mitc_pkg::OP_MOVMA, 0, 0, 9));
		p(2, wi(mitc_pkg::OP_ADDI, 8'h80));
		p(3, wm(mitc_pkg::OP_ADC, 0, 0, 9));
		p(4, wi(mitc_pkg::OP_SUBI, 8'h90));
		p(5, wm(mitc_pkg::OP_SBC, 0, 0, 9));
		p(6, wm(mitc_pkg::OP_RR, 0, 0, 9));
		p(7, wm(mitc_pkg::OP_RL, 0, 0, 9));
		p(8, wm(mitc_pkg::OP_SZB, 0, 1, 9));
		p(9, wi(mitc_pkg::OP_MOVAI, 8'h44));
		p(10, wi(mitc_pkg::OP_MOVAI, 8'h66));
		go();
		step(2);
		sa(8'h01);
		`CHK("c_addi", 1'b1, carry_flag)
		sa(8'h83);
		`CHK("c_adc", 1'b0, carry_flag)
		sa(8'hF3);
		`CHK("b_subi", 1'b1, carry_flag)
		sa(8'h71);
		`CHK("b_sbc", 1'b0, carry_flag)
		sa(8'hC0);
		sa(8'h03);
		`CHK("c_rot", 1'b0, carry_flag)
		step(1);
		`CHK("gap_szb", 8, gap)
		`CHK("pc_szb", 11'h00A, pc)
		sa(8'h66);
	endtask

	task s_call;
		restart();
		p(0, wj(mitc_pkg::OP_CALL, 11'h010));
		p(1, wj(mitc_pkg::OP_CALL, 11'h020));
		p(16, wi(mitc_pkg::OP_MOVAI, 8'h55));
		p(17, wj(mitc_pkg::OP_RET, 11'h000));
		p(32, wj(mitc_pkg::OP_INTERRUPT_EXIT, 11'h000));
		go();
		step(1);
		`CHK("gap_call", 8, gap)
		`CHK("pc_call", 11'h010, pc)
		step(2);
		`CHK("pc_ret", 11'h001, pc)
		`CHK("gie_ret", 1'b0, gie)
		`CHK("acc_sub", 8'h55, acc)
		step(2);
		`CHK("pc_interrupt_exit", 11'h002, pc)
		`CHK("gie_interrupt_exit", 1'b1, gie)
	endtask

	task s_table;
		restart();
		p(0, wi(mitc_pkg::OP_MOVAI, 8'h40));
		p(1, wj(mitc_pkg::OP_TBLRD, 11'h000));
		p(2, wi(mitc_pkg::OP_MOVAI, 8'h30));
		p(3, wm(mitc_pkg::OP_MOVMA, 0, 0, mitc_pkg::PCL_ADDR));
		p(64, 16'h12A5);
		go();
		step(1);
		sa(8'hA5);
		`CHK("gap_tbl", 8, gap)
		step(2);
		`CHK("gap_pcl", 8, gap)
		`CHK("pc_pcl", 11'h030, pc)
		step(1);
		`CHK("pc_after", 11'h031, pc)
	endtask

	task s_halt;
		restart();
		p(0, wj(mitc_pkg::OP_HALT, 11'h000));
		p(1, wi(mitc_pkg::OP_MOVAI, 8'h33));
		go();
		step(1);
		repeat (12) @(negedge clk_sys);
		`CHK("pdown", 1'b1, power_down)
		`CHK("acc_sleep", 8'h00, acc)
		wake = 1'b1;
		for (int k = 0; k < 16 && power_down === 1'b1; k++) @(negedge clk_sys);
		`CHK("woken", 1'b0, power_down)
		wake = 1'b0;
		sa(8'h33);
		`CHK("fast_src", mitc_pkg::OSC_XTAL, fast_src)
		`CHK("slow_src", mitc_pkg::OSC_XTAL, slow_src)
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#50000;
		fail_count++;
		summarize();
	end

	initial begin
		s_timing();
		s_alu();
		s_mem();
		s_skip();
		s_more();
		s_call();
		s_table();
		s_halt();
		summarize();
	end
endmodule
`default_nettype wire
